// ---- src/blk_mem_core.sv ----
// block memory access with per-area write policy
// What this block does
// - store 64 blocks of 32 bits each
// - every access moves one whole block
// - decode exactly nine protocol commands
// - otp writes only clear bits
// - reload command sets whole otp area
// - two 32-bit counters that only decrement
// - general blocks erased before each program
// - otp area is blocks 0 to 4
// - counters are blocks 5 and 6
// - general area is blocks 7 to 63
// - writes replace all 32 bits together
// - read returns any block unconditionally
`timescale 1ns/1ps
`include "blk_mem_map.svh"
module blk_mem_core
#(
   parameter int PROG_CYCLES = `BLK_PROG_CYC
)
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire blk_mem_pkg::mem_req_t req,
   output logic req_ready,
   output blk_mem_pkg::mem_rsp_t rsp
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_PROG = 2'b10
   } state_t;

   state_t state_q;
   state_t state_d;
   logic [31:0] mem_q [`BLK_NUM_BLOCKS];
   logic [31:0] prog_cnt_q;
   logic [5:0] addr_q;
   logic [31:0] word_q;
   logic reload_q;
   blk_mem_pkg::mem_rsp_t rsp_q;

   // maps a block address to its area
   function automatic blk_mem_pkg::area_t area_of(input logic [5:0] a);
      if (a <= `BLK_OTP_LAST)
         return blk_mem_pkg::AREA_OTP;
      else if (a <= `BLK_CNT_LAST)
         return blk_mem_pkg::AREA_COUNTER;
      else
         return blk_mem_pkg::AREA_GENERAL;
   endfunction : area_of

   // recognised protocol commands; the otp reload is not among them and is decoded on its own
   function automatic logic is_proto(input blk_mem_pkg::cmd_t c);
      return (c <= blk_mem_pkg::CMD_UNIQUE_ID_READ);
   endfunction : is_proto

   wire is_idle = (state_q == ST_IDLE);
   wire take = req.valid && is_idle;
   wire is_wr = (req.cmd == blk_mem_pkg::CMD_WRITE_BLOCK);
   wire is_rd = (req.cmd == blk_mem_pkg::CMD_READ_BLOCK);
   wire is_rl = (req.cmd == blk_mem_pkg::CMD_OTP_RELOAD);
   wire blk_mem_pkg::area_t wr_area = area_of(req.addr);
   wire [31:0] old_word = mem_q[req.addr];
   wire [31:0] merged;
   wire accepted;
   wire prog_done = (prog_cnt_q == 32'h0000_0001);

   blk_write_merge u_merge
   (
      .area(wr_area),
      .old_word(old_word),
      .new_word(req.data),
      .merged(merged),
      .accepted(accepted)
   );

   // stall new requests while the nonvolatile cycle runs
   assign req_ready = is_idle;
   assign rsp = rsp_q;

   // program phase lasts PROG_CYCLES, mirroring the self-timed cycle
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (take && ((is_wr && accepted) || is_rl))
               state_d = ST_PROG;
         ST_PROG:
            if (prog_done)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   // state and program counter
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state_q <= ST_IDLE;
         prog_cnt_q <= 32'h0000_0000;
      end
      else
      begin
         state_q <= state_d;
         if (state_q == ST_IDLE)
            prog_cnt_q <= PROG_CYCLES[31:0];
         else
            prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
      end
   end

   // latch the merged word; commits at end of program so a write is atomic
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         addr_q <= 6'h00;
         word_q <= 32'h0000_0000;
         reload_q <= 1'b0;
      end
      else if (take)
      begin
         addr_q <= req.addr;
         word_q <= merged;
         reload_q <= is_rl;
      end
   end

   // array update; counters start full so they can only count down from all ones
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < `BLK_NUM_BLOCKS; i++)
            mem_q[i] <= `BLK_ONES;
      end
      else if (state_q == ST_PROG && prog_done)
      begin
         if (reload_q)
         begin
            for (int i = 0; i <= `BLK_OTP_LAST; i++)
               mem_q[i] <= `BLK_ONES;
         end
         else
            mem_q[addr_q] <= word_q;
      end
   end

   // one answer pulse per taken request; reads ignore protection
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         rsp_q <= '0;
      else
      begin
         rsp_q.valid <= take;
         rsp_q.known <= take && (is_proto(req.cmd) || is_rl);
         rsp_q.data <= (take && is_rd) ? old_word : `BLK_ZERO;
         rsp_q.changed <= take && ((is_wr && accepted) || is_rl);
      end
   end

   // a counter block never grows between two cycles
   a_counter_no_rise: assert property (@(posedge ref_clk) disable iff (srst)
      $past(!srst) |->
      (mem_q[5] <= $past(mem_q[5])))
      else $error("counter 5 increased");

   // the second counter obeys the same rule
   a_counter6_no_rise: assert property (@(posedge ref_clk) disable iff (srst)
      $past(!srst) |->
      (mem_q[6] <= $past(mem_q[6])))
      else $error("counter 6 increased");

   // otp never regains a one except by reload
   a_otp_clear_only: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == ST_PROG && prog_done && !reload_q) |=>
      ((mem_q[0] & ~$past(mem_q[0])) == 32'h0000_0000))
      else $error("otp bit set by write");

   // same guard on the last otp block
   a_otp4_clear_only: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == ST_PROG && prog_done && !reload_q) |=>
      ((mem_q[4] & ~$past(mem_q[4])) == 32'h0000_0000))
      else $error("otp block 4 bit set by write");

   // a reload leaves otp all ones
   a_reload_ones: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == ST_PROG && prog_done && reload_q) |=>
      (mem_q[4] == `BLK_ONES && mem_q[0] == `BLK_ONES))
      else $error("otp not reloaded");

   // reload must not spill into counter block 5
   a_reload_keeps_cnt: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == ST_PROG && prog_done && reload_q) |=>
      (mem_q[5] == $past(mem_q[5])))
      else $error("reload touched a counter");

   // read answer next cycle with stored word
   a_read_data: assert property (@(posedge ref_clk) disable iff (srst)
      (take && is_rd) |=>
      (rsp.valid && rsp.data == $past(old_word)))
      else $error("read data wrong");

   // general write lands whole word
   a_gen_write: assert property (@(posedge ref_clk) disable iff (srst)
      (take && is_wr && req.addr >= `BLK_GEN_FIRST) |=>
      (word_q == $past(req.data)))
      else $error("general write not whole");

   // the latched word reaches the array at the end of programming
   a_commit_word: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == ST_PROG && prog_done && !reload_q) |=>
      (mem_q[$past(addr_q)] == $past(word_q)))
      else $error("committed word differs");

   // nothing is taken while the cell cycle runs
   a_busy_stall: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == ST_PROG) |->
      !req_ready)
      else $error("ready during programming");

   // every taken request gets exactly one answer pulse
   a_rsp_follows: assert property (@(posedge ref_clk) disable iff (srst)
      (req.valid && req_ready) |=>
      rsp.valid)
      else $error("taken request not answered");

   // no answer without a taken request
   a_no_spurious_rsp: assert property (@(posedge ref_clk) disable iff (srst)
      !(req.valid && req_ready) |=>
      !rsp.valid)
      else $error("answer without request");

   // an accepted write starts a program cycle
   a_write_to_prog: assert property (@(posedge ref_clk) disable iff (srst)
      (take && is_wr && accepted) |=>
      (state_q == ST_PROG))
      else $error("write did not start programming");

   // a refused counter write leaves everything idle and unchanged
   a_cnt_refused: assert property (@(posedge ref_clk) disable iff (srst)
      (take && is_wr && wr_area == blk_mem_pkg::AREA_COUNTER && !accepted) |=>
      (state_q == ST_IDLE && !rsp.changed))
      else $error("refused counter write acted");

   // reload is recognised and reported as a change
   a_reload_rsp: assert property (@(posedge ref_clk) disable iff (srst)
      (take && is_rl) |=>
      (rsp.known && rsp.changed))
      else $error("reload not reported");

   // the nine protocol commands are recognised
   a_proto_known: assert property (@(posedge ref_clk) disable iff (srst)
      (take && is_proto(req.cmd)) |=>
      rsp.known)
      else $error("protocol command not known");

   // anything outside the set, other than the otp reload, is reported unknown
   a_unknown_cmd: assert property (@(posedge ref_clk) disable iff (srst)
      (take && !is_proto(req.cmd) && !is_rl) |=>
      !rsp.known)
      else $error("unknown command accepted");

   // program counter stays within its window while busy
   a_prog_count: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == ST_PROG) |->
      (prog_cnt_q >= 32'h0000_0001 && prog_cnt_q <= PROG_CYCLES))
      else $error("program counter out of range");

   // the last program cycle returns to idle
   a_prog_ends: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == ST_PROG && prog_done) |=>
      (state_q == ST_IDLE))
      else $error("programming did not end");

   // idle cycles never disturb stored words
   a_idle_keeps_mem: assert property (@(posedge ref_clk) disable iff (srst)
      (state_q == ST_IDLE) |=>
      (mem_q[7] == $past(mem_q[7]) && mem_q[0] == $past(mem_q[0])))
      else $error("memory changed while idle");

   // area decode of the low blocks
   a_otp_area: assert property (@(posedge ref_clk) disable iff (srst)
      (req.addr <= `BLK_OTP_LAST) |->
      (wr_area == blk_mem_pkg::AREA_OTP))
      else $error("otp area decode wrong");

   // area decode of the counter blocks
   a_cnt_area: assert property (@(posedge ref_clk) disable iff (srst)
      (req.addr == `BLK_CNT_FIRST || req.addr == `BLK_CNT_LAST) |->
      (wr_area == blk_mem_pkg::AREA_COUNTER))
      else $error("counter area decode wrong");

   // area decode of the general blocks
   a_gen_area: assert property (@(posedge ref_clk) disable iff (srst)
      (req.addr >= `BLK_GEN_FIRST) |->
      (wr_area == blk_mem_pkg::AREA_GENERAL))
      else $error("general area decode wrong");

   // state register keeps a legal one-hot code
   a_state_onehot: assert property (@(posedge ref_clk) disable iff (srst)
      $onehot(state_q))
      else $error("state code illegal");
endmodule : blk_mem_core

// ---- src/blk_mem_map.svh ----
// block map, field positions and timing counts for the block memory
`ifndef BLK_MEM_MAP_SVH
`define BLK_MEM_MAP_SVH
`define BLK_NUM_BLOCKS 64
`define BLK_WORD_BITS 32
`define BLK_ADDR_BITS 6
`define BLK_OTP_FIRST 6'h00
`define BLK_OTP_LAST 6'h04
`define BLK_CNT_FIRST 6'h05
`define BLK_CNT_LAST 6'h06
`define BLK_GEN_FIRST 6'h07
`define BLK_GEN_LAST 6'h3f
`define BLK_ONES 32'hffff_ffff
`define BLK_ZERO 32'h0000_0000
`define BLK_PROG_NS 5000
`define BLK_CLK_NS 5
`define BLK_PROG_CYC ((`BLK_PROG_NS + `BLK_CLK_NS - 1) / `BLK_CLK_NS)
`endif

// ---- src/blk_mem_pkg.sv ----
// types shared by the block memory write policy logic
package blk_mem_pkg;
   typedef enum logic [3:0] {
      CMD_READ_BLOCK = 4'h0,
      CMD_WRITE_BLOCK = 4'h1,
      CMD_INITIATE = 4'h2,
      CMD_SIXTEEN_SLOT_POLL = 4'h3,
      CMD_SLOT_MARKER = 4'h4,
      CMD_SELECT = 4'h5,
      CMD_COMPLETION = 4'h6,
      CMD_RETURN_TO_INVENTORY = 4'h7,
      CMD_UNIQUE_ID_READ = 4'h8,
      CMD_OTP_RELOAD = 4'h9
   } cmd_t;

   typedef enum logic [1:0] {
      AREA_OTP = 2'h0,
      AREA_COUNTER = 2'h1,
      AREA_GENERAL = 2'h2
   } area_t;

   typedef struct packed {
      logic valid;
      cmd_t cmd;
      logic [5:0] addr;
      logic [31:0] data;
   } mem_req_t;

   typedef struct packed {
      logic valid;
      logic known;
      logic [31:0] data;
      logic changed;
   } mem_rsp_t;
endpackage : blk_mem_pkg

// ---- src/blk_write_merge.sv ----
// per-area merge of a written word with the stored word
`timescale 1ns/1ps
`include "blk_mem_map.svh"
module blk_write_merge
(
   input wire blk_mem_pkg::area_t area,
   input wire logic [31:0] old_word,
   input wire logic [31:0] new_word,
   output logic [31:0] merged,
   output logic accepted
);
   // counter only accepts values not above the count
   wire cnt_ok = (new_word <= old_word);

   // otp: and keeps cleared bits cleared; general: erase then program gives new word
   assign merged = (area == blk_mem_pkg::AREA_OTP) ? (old_word & new_word) :
                   (area == blk_mem_pkg::AREA_COUNTER) ? (cnt_ok ? new_word : old_word) :
                   new_word;
   assign accepted = (area != blk_mem_pkg::AREA_COUNTER) || cnt_ok;
endmodule : blk_write_merge

// ---- dv/reader_model.sv ----
// reader side model that presents one command request at a time
`timescale 1ns/1ps
module reader_model
(
   input wire logic ref_clk,
   input wire blk_mem_pkg::mem_req_t job,
   output blk_mem_pkg::mem_req_t req
);
   blk_mem_pkg::mem_req_t last_q = '0;
   // keep the last request so that a released bus shows its inverse
   always @(posedge ref_clk)
   begin
      if (job.valid)
      begin
         last_q <= job;
      end
   end
   // a whole 32-bit word goes with every request
   assign req = job.valid ? job : {1'b0, ~last_q[41:0]};
endmodule : reader_model

// ---- dv/blk_mem_core_tb.sv ----
// self-checking bench for the block memory write policy
`timescale 1ns/1ps
module blk_mem_core_tb;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic req_ready;
   blk_mem_pkg::mem_req_t job = '0;
   blk_mem_pkg::mem_req_t req;
   blk_mem_pkg::mem_rsp_t rsp;
   blk_mem_pkg::mem_rsp_t r;
   int errors = 0;
   int comparisons = 0;
   always #2.5 ref_clk = ~ref_clk;
   reader_model reader_model_i (.ref_clk(ref_clk), .job(job), .req(req));
   // short programming time keeps the run brief
   blk_mem_core #(.PROG_CYCLES(4)) blk_mem_core_i
   (
      .ref_clk(ref_clk),
      .srst(srst),
      .req(req),
      .req_ready(req_ready),
      .rsp(rsp)
   );
   task automatic test_done;
      if (errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp32
   task automatic cmp1(input logic g, input logic e);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp1
   // one request, driven once ready is seen and dropped after one cycle; the answer is caught in its single cycle
   task automatic acc(input logic [3:0] c, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1)
      begin
         @(negedge ref_clk);
         n++;
         if (n > 50)
         begin
            errors++;
            test_done();
         end
      end
      job <= {1'b1, c, a, d};
      @(negedge ref_clk);
      r = rsp;
      job <= '0;
      cmp1(r.valid, 1'b1);
      @(negedge ref_clk);
   endtask : acc
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      acc(4'h0, a, 32'h0000_0000);
      cmp32(r.data, e);
   endtask : rd
   initial
   begin
      repeat (2) @(negedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      rd(6'h00, 32'hffff_ffff);
      rd(6'h3f, 32'hffff_ffff);
      rd(6'h05, 32'hffff_ffff);
      acc(4'h1, 6'h02, 32'h1234_5678);
      rd(6'h02, 32'h1234_5678);
      acc(4'h1, 6'h02, 32'hffff_00ff);
      rd(6'h02, 32'h1234_0078);
      acc(4'h1, 6'h04, 32'h0000_0000);
      rd(6'h04, 32'h0000_0000);
      acc(4'h9, 6'h00, 32'h0000_0000);
      cmp1(r.known, 1'b1);
      rd(6'h02, 32'hffff_ffff);
      rd(6'h04, 32'hffff_ffff);
      acc(4'h1, 6'h05, 32'h0000_0010);
      cmp1(r.changed, 1'b1);
      cmp1(req_ready, 1'b0);
      rd(6'h05, 32'h0000_0010);
      acc(4'h1, 6'h05, 32'h0000_0020);
      cmp1(r.changed, 1'b0);
      cmp1(req_ready, 1'b1);
      rd(6'h05, 32'h0000_0010);
      acc(4'h1, 6'h06, 32'h0000_0000);
      rd(6'h06, 32'h0000_0000);
      // the second value sets bits the first cleared: only an erase gets there
      acc(4'h1, 6'h07, 32'ha5a5_a5a5);
      acc(4'h1, 6'h07, 32'h0f0f_0f0f);
      rd(6'h07, 32'h0f0f_0f0f);
      acc(4'h1, 6'h3f, 32'h5a5a_5a5a);
      rd(6'h3f, 32'h5a5a_5a5a);
      acc(4'h1, 6'h3f, 32'hc3c3_3c3c);
      rd(6'h3f, 32'hc3c3_3c3c);
      rd(6'h06, 32'h0000_0000);
      for (int c = 2; c <= 8; c++)
      begin
         acc(c[3:0], 6'h00, 32'h0000_0000);
         cmp1(r.known, 1'b1);
      end
      acc(4'hf, 6'h00, 32'h0000_0000);
      cmp1(r.known, 1'b0);
      test_done();
   end
endmodule : blk_mem_core_tb
